/* File: include/duhbp_pkg.sv */
/*
  Constants, pin bundle layout, timing counts and the pin filter function
  shared by both ends of the dual-channel parallel register port.
  Assumes both ends run on one 40 MHz clock and see each other only
  through the pins carried by duhbp_bus_if.

  // What this block does
  // - three select lines pick one of eight registers
  // - eight-bit shared bus; device drives only reads
  // - read strobe fall fetches the addressed register
  // - byte held while strobe low; host captures on rise
  // - write strobe rise loads bus byte into register
  // - channel A answers only while its select low
  // - channel B answers only while its select low
  // - A control bit3 set: irq driven, aux2 low
  // - A control bit3 clear: irq released, aux2 high
  // - B irq and aux2 follow its bit3 alike
  // - control bit3 resets to zero in both channels
  // - A transmit ready output, active low
  // - A receive ready output, active low
  // - B transmit ready output, active low
  // - B receive ready output, active low
  // - board leaves aux2 alone while irq used
*/
package duhbp_pkg;

    localparam int unsigned ADDR_W        = 3;
    localparam int unsigned DATA_W        = 8;
    localparam int unsigned REG_COUNT     = 8;
    localparam int unsigned CHAN_COUNT    = 2;

    // modem-control register index and its output-2 bit
    localparam logic [2:0]  MODEM_CTRL_IDX = 3'h4;
    localparam int unsigned MODEM_CTRL_OUT2 = 3;
    localparam logic [7:0]  REG_RESET_VAL  = 8'h00;

    // host bus timing, 40 MHz clock
    localparam int unsigned CLK_MHZ       = 40;
    localparam int unsigned SETUP_NS      = 50;
    localparam int unsigned STROBE_NS     = 400;
    localparam int unsigned RECOVER_NS    = 200;
    localparam int unsigned SETUP_CYC     = (SETUP_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned STROBE_CYC    = (STROBE_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned RECOVER_CYC   = (RECOVER_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned CNT_W         = 5;

    // pins seen by the device, in one bundle
    typedef struct packed {
        logic       rd_n;
        logic       wr_n;
        logic       csa_n;
        logic       csb_n;
        logic [2:0] addr;
        logic [7:0] data;
    } duhbp_dev_pins_type;

    // pins seen by the host, in one bundle
    typedef struct packed {
        logic [1:0] irq;
        logic [1:0] tx_ready_n;
        logic [1:0] rx_ready_n;
        logic [7:0] data;
    } duhbp_host_pins_type;

    typedef enum logic [1:0] {
        HOST_IDLE    = 2'b00,
        HOST_SETUP   = 2'b01,
        HOST_STROBE  = 2'b11,
        HOST_RECOVER = 2'b10
    } duhbp_host_state_type;

    // a filtered bit moves only once the second and third stages agree
    function automatic logic [15:0] pin_filter(input logic [15:0] held,
                                               input logic [15:0] s2,
                                               input logic [15:0] s3);
        pin_filter = (s2 & s3) | (held & (s2 | s3));
    endfunction : pin_filter

endpackage : duhbp_pkg

/* File: include/duhbp_bus_if.sv */
/*
  Pin carrier between the host end and the device end.
  Assumes a passive pull-up on the data bus and on each irq line: an
  undriven line reads as one.
*/
`timescale 1ns/1ps
`default_nettype none
interface duhbp_bus_if;
    logic [2:0] reg_select_lines;
    logic       read_strobe_n;
    logic       write_strobe_n;
    logic       chan_a_select_n;
    logic       chan_b_select_n;
    logic [7:0] host_data_o;
    logic       host_data_oe;
    logic [7:0] dev_data_o;
    logic       dev_data_oe;
    logic [7:0] bus_byte;
    logic       chan_a_irq_o;
    logic       chan_a_irq_oe;
    logic       chan_b_irq_o;
    logic       chan_b_irq_oe;
    logic       chan_a_irq_out;
    logic       chan_b_irq_out;
    logic       chan_a_aux_out2_n;
    logic       chan_b_aux_out2_n;
    logic       chan_a_tx_ready_n;
    logic       chan_a_rx_ready_n;
    logic       chan_b_tx_ready_n;
    logic       chan_b_rx_ready_n;

    // resolved levels of the shared lines
    assign bus_byte       = dev_data_oe ? dev_data_o :
                            (host_data_oe ? host_data_o : 8'hff);
    assign chan_a_irq_out = chan_a_irq_oe ? chan_a_irq_o : 1'b1;
    assign chan_b_irq_out = chan_b_irq_oe ? chan_b_irq_o : 1'b1;

    modport host_port (
        output reg_select_lines, read_strobe_n, write_strobe_n,
        output chan_a_select_n, chan_b_select_n, host_data_o, host_data_oe,
        input  bus_byte, chan_a_irq_out, chan_b_irq_out,
        input  chan_a_aux_out2_n, chan_b_aux_out2_n,
        input  chan_a_tx_ready_n, chan_a_rx_ready_n,
        input  chan_b_tx_ready_n, chan_b_rx_ready_n
    );

    modport device_port (
        input  reg_select_lines, read_strobe_n, write_strobe_n,
        input  chan_a_select_n, chan_b_select_n, bus_byte,
        output dev_data_o, dev_data_oe,
        output chan_a_irq_o, chan_a_irq_oe, chan_b_irq_o, chan_b_irq_oe,
        output chan_a_aux_out2_n, chan_b_aux_out2_n,
        output chan_a_tx_ready_n, chan_a_rx_ready_n,
        output chan_b_tx_ready_n, chan_b_rx_ready_n
    );
endinterface : duhbp_bus_if
`default_nettype wire

/* File: verilog/duhbp_device_end.sv */
/*
  Device end of the dual-channel register port: two banks of eight byte
  registers reached by the host strobes, interrupt and ready pins.
  Assumes the host pins are asynchronous to clk_in and that the host
  keeps its strobes low long enough for the filtered pins to follow.
*/
`timescale 1ns/1ps
`default_nettype none
module duhbp_device_end (
    // clock and reset
    input  wire logic                      clk_in,
    input  wire logic                      srst_in,
    // pins toward the host
    duhbp_bus_if.device_port               bus,
    // per-channel status from the uart core
    input  wire logic [1:0]                chan_irq_req_in,
    input  wire logic [1:0]                chan_tx_space_in,
    input  wire logic [1:0]                chan_rx_avail_in,
    // register access events toward the uart core
    output logic                           wr_pulse_out,
    output logic                           rd_pulse_out,
    output logic                           acc_chan_out,
    output logic [2:0]                     acc_addr_out,
    output logic [7:0]                     wr_data_out,
    output logic [1:0]                     irq_enable_out
);

    duhbp_pkg::duhbp_dev_pins_type pins_now;
    duhbp_pkg::duhbp_dev_pins_type s1_r;
    duhbp_pkg::duhbp_dev_pins_type s2_r;
    duhbp_pkg::duhbp_dev_pins_type s3_r;
    duhbp_pkg::duhbp_dev_pins_type filt_r;
    duhbp_pkg::duhbp_dev_pins_type filt_nxt;
    logic [15:0]                   filt_wide;
    duhbp_pkg::duhbp_dev_pins_type prev_r;

    logic [7:0] regs_r   [2][8];
    logic [7:0] regs_nxt [2][8];

    logic       rd_fall;
    logic       wr_rise;
    logic       rd_hit;
    logic       wr_hit;
    logic       rd_chan;
    logic       wr_chan;

    logic [7:0] dev_data_r;
    logic [7:0] dev_data_nxt;
    logic       dev_oe_r;
    logic       dev_oe_nxt;
    logic [1:0] irq_o_r;
    logic [1:0] irq_o_nxt;
    logic [1:0] irq_oe_r;
    logic [1:0] irq_oe_nxt;
    logic [1:0] aux2_n_r;
    logic [1:0] aux2_n_nxt;
    logic [1:0] tx_rdy_n_r;
    logic [1:0] tx_rdy_n_nxt;
    logic [1:0] rx_rdy_n_r;
    logic [1:0] rx_rdy_n_nxt;
    logic       wr_pulse_r;
    logic       wr_pulse_nxt;
    logic       rd_pulse_r;
    logic       rd_pulse_nxt;
    logic       acc_chan_r;
    logic       acc_chan_nxt;
    logic [2:0] acc_addr_r;
    logic [2:0] acc_addr_nxt;
    logic [7:0] wr_data_r;
    logic [7:0] wr_data_nxt;

    assign pins_now.rd_n  = bus.read_strobe_n;
    assign pins_now.wr_n  = bus.write_strobe_n;
    assign pins_now.csa_n = bus.chan_a_select_n;
    assign pins_now.csb_n = bus.chan_b_select_n;
    assign pins_now.addr  = bus.reg_select_lines;
    assign pins_now.data  = bus.bus_byte;

    // pin synchroniser: s1 feeds only s2; filter looks at s2 and s3
    always_comb begin
        filt_wide = duhbp_pkg::pin_filter(16'(filt_r), 16'(s2_r), 16'(s3_r));
        filt_nxt  = duhbp_pkg::duhbp_dev_pins_type'(filt_wide[14:0]);
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            s1_r   <= '1;
            s2_r   <= '1;
            s3_r   <= '1;
            filt_r <= '1;
            prev_r <= '1;
        end else begin
            s1_r   <= pins_now;
            s2_r   <= s1_r;
            s3_r   <= s2_r;
            filt_r <= filt_nxt;
            prev_r <= filt_r;
        end
    end

    // strobe edges of the filtered pins; exactly one select must be low
    assign rd_fall = prev_r.rd_n & ~filt_r.rd_n;
    assign wr_rise = ~prev_r.wr_n & filt_r.wr_n;
    assign rd_hit  = rd_fall & (filt_r.csa_n ^ filt_r.csb_n);
    assign wr_hit  = wr_rise & (prev_r.csa_n ^ prev_r.csb_n);
    assign rd_chan = filt_r.csa_n;
    assign wr_chan = prev_r.csa_n;

    // register banks: the write takes the byte held while strobe was low
    always_comb begin
        regs_nxt = regs_r;
        if (wr_hit) begin
            regs_nxt[wr_chan][prev_r.addr] = prev_r.data;
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            for (int c = 0; c < 2; c++) begin
                for (int r = 0; r < 8; r++) begin
                    regs_r[c][r] <= duhbp_pkg::REG_RESET_VAL;
                end
            end
        end else begin
            regs_r <= regs_nxt;
        end
    end

    // read data path and pin outputs
    always_comb begin
        dev_data_nxt = dev_data_r;
        dev_oe_nxt   = dev_oe_r;
        if (rd_hit) begin
            dev_data_nxt = regs_r[rd_chan][filt_r.addr];
            dev_oe_nxt   = 1'b1;
        end else if (filt_r.rd_n) begin
            dev_oe_nxt   = 1'b0;
        end
        for (int c = 0; c < 2; c++) begin
            irq_o_nxt[c]    = chan_irq_req_in[c];
            irq_oe_nxt[c]   = regs_r[c][duhbp_pkg::MODEM_CTRL_IDX]
                                    [duhbp_pkg::MODEM_CTRL_OUT2];
            aux2_n_nxt[c]   = ~irq_oe_nxt[c];
            tx_rdy_n_nxt[c] = ~chan_tx_space_in[c];
            rx_rdy_n_nxt[c] = ~chan_rx_avail_in[c];
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            dev_data_r <= 8'h00;
            dev_oe_r   <= 1'b0;
            irq_o_r    <= 2'h0;
            irq_oe_r   <= 2'h0;
            aux2_n_r   <= 2'h3;
            tx_rdy_n_r <= 2'h3;
            rx_rdy_n_r <= 2'h3;
        end else begin
            dev_data_r <= dev_data_nxt;
            dev_oe_r   <= dev_oe_nxt;
            irq_o_r    <= irq_o_nxt;
            irq_oe_r   <= irq_oe_nxt;
            aux2_n_r   <= aux2_n_nxt;
            tx_rdy_n_r <= tx_rdy_n_nxt;
            rx_rdy_n_r <= rx_rdy_n_nxt;
        end
    end

    // access events toward the uart core
    always_comb begin
        wr_pulse_nxt = wr_hit;
        rd_pulse_nxt = rd_hit;
        acc_chan_nxt = acc_chan_r;
        acc_addr_nxt = acc_addr_r;
        wr_data_nxt  = wr_data_r;
        if (wr_hit) begin
            acc_chan_nxt = wr_chan;
            acc_addr_nxt = prev_r.addr;
            wr_data_nxt  = prev_r.data;
        end else if (rd_hit) begin
            acc_chan_nxt = rd_chan;
            acc_addr_nxt = filt_r.addr;
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            wr_pulse_r <= 1'b0;
            rd_pulse_r <= 1'b0;
            acc_chan_r <= 1'b0;
            acc_addr_r <= 3'h0;
            wr_data_r  <= 8'h00;
        end else begin
            wr_pulse_r <= wr_pulse_nxt;
            rd_pulse_r <= rd_pulse_nxt;
            acc_chan_r <= acc_chan_nxt;
            acc_addr_r <= acc_addr_nxt;
            wr_data_r  <= wr_data_nxt;
        end
    end

    assign bus.dev_data_o        = dev_data_r;
    assign bus.dev_data_oe       = dev_oe_r;
    assign bus.chan_a_irq_o      = irq_o_r[0];
    assign bus.chan_b_irq_o      = irq_o_r[1];
    assign bus.chan_a_irq_oe     = irq_oe_r[0];
    assign bus.chan_b_irq_oe     = irq_oe_r[1];
    assign bus.chan_a_aux_out2_n = aux2_n_r[0];
    assign bus.chan_b_aux_out2_n = aux2_n_r[1];
    assign bus.chan_a_tx_ready_n = tx_rdy_n_r[0];
    assign bus.chan_b_tx_ready_n = tx_rdy_n_r[1];
    assign bus.chan_a_rx_ready_n = rx_rdy_n_r[0];
    assign bus.chan_b_rx_ready_n = rx_rdy_n_r[1];

    assign wr_pulse_out   = wr_pulse_r;
    assign rd_pulse_out   = rd_pulse_r;
    assign acc_chan_out   = acc_chan_r;
    assign acc_addr_out   = acc_addr_r;
    assign wr_data_out    = wr_data_r;
    assign irq_enable_out = irq_oe_r;

endmodule : duhbp_device_end
`default_nettype wire

/* File: verilog/duhbp_host_end.sv */
/*
  Host end of the dual-channel register port: turns one command into a
  timed read or write cycle on the pins, and filters the device pins.
  Assumes the device end filters its pins through three flops.
*/
`timescale 1ns/1ps
`default_nettype none
module duhbp_host_end (
    // clock and reset
    input  wire logic                      clk_in,
    input  wire logic                      srst_in,
    // pins toward the device
    duhbp_bus_if.host_port                 bus,
    // command port
    input  wire logic                      cmd_valid_in,
    input  wire logic                      cmd_write_in,
    input  wire logic                      cmd_chan_in,
    input  wire logic [2:0]                cmd_addr_in,
    input  wire logic [7:0]                cmd_data_in,
    output logic                           cmd_ready_out,
    output logic                           done_out,
    output logic [7:0]                     rd_data_out,
    // filtered device status
    output logic [1:0]                     irq_out,
    output logic [1:0]                     tx_ready_n_out,
    output logic [1:0]                     rx_ready_n_out
);

    localparam logic [4:0] SETUP_LAST   = 5'(duhbp_pkg::SETUP_CYC - 1);
    localparam logic [4:0] STROBE_LAST  = 5'(duhbp_pkg::STROBE_CYC - 1);
    localparam logic [4:0] RECOVER_LAST = 5'(duhbp_pkg::RECOVER_CYC - 1);

    duhbp_pkg::duhbp_host_state_type state_r;
    duhbp_pkg::duhbp_host_state_type state_nxt;
    duhbp_pkg::duhbp_host_pins_type  pins_now;
    duhbp_pkg::duhbp_host_pins_type  s1_r;
    duhbp_pkg::duhbp_host_pins_type  s2_r;
    duhbp_pkg::duhbp_host_pins_type  s3_r;
    duhbp_pkg::duhbp_host_pins_type  filt_r;
    duhbp_pkg::duhbp_host_pins_type  filt_nxt;
    logic [15:0]                     filt_wide;
    // ready, select a, select b, read, write, data drive
    logic [5:0]                      drv_r;
    logic [5:0]                      drv_nxt;

    logic [4:0] cnt_r;
    logic [4:0] cnt_nxt;
    logic       write_r;
    logic       write_nxt;
    logic       chan_r;
    logic       chan_nxt;
    logic [2:0] addr_r;
    logic [2:0] addr_nxt;
    logic [7:0] data_r;
    logic [7:0] data_nxt;
    logic [7:0] rd_data_r;
    logic [7:0] rd_data_nxt;
    logic       done_r;
    logic       done_nxt;

    assign pins_now.irq        = {bus.chan_b_irq_out, bus.chan_a_irq_out};
    assign pins_now.tx_ready_n = {bus.chan_b_tx_ready_n, bus.chan_a_tx_ready_n};
    assign pins_now.rx_ready_n = {bus.chan_b_rx_ready_n, bus.chan_a_rx_ready_n};
    assign pins_now.data       = bus.bus_byte;

    always_comb begin
        filt_wide = duhbp_pkg::pin_filter(16'(filt_r), 16'(s2_r), 16'(s3_r));
        filt_nxt  = duhbp_pkg::duhbp_host_pins_type'(filt_wide[13:0]);
    end

    // command sequencer
    always_comb begin
        state_nxt   = state_r;
        cnt_nxt     = cnt_r + 5'h01;
        write_nxt   = write_r;
        chan_nxt    = chan_r;
        addr_nxt    = addr_r;
        data_nxt    = data_r;
        rd_data_nxt = rd_data_r;
        done_nxt    = 1'b0;
        case (state_r)
            duhbp_pkg::HOST_IDLE: begin
                cnt_nxt = 5'h00;
                if (cmd_valid_in) begin
                    write_nxt = cmd_write_in;
                    chan_nxt  = cmd_chan_in;
                    addr_nxt  = cmd_addr_in;
                    data_nxt  = cmd_data_in;
                    state_nxt = duhbp_pkg::HOST_SETUP;
                end
            end
            duhbp_pkg::HOST_SETUP: begin
                if (cnt_r == SETUP_LAST) begin
                    cnt_nxt   = 5'h00;
                    state_nxt = duhbp_pkg::HOST_STROBE;
                end
            end
            duhbp_pkg::HOST_STROBE: begin
                if (cnt_r == STROBE_LAST) begin
                    cnt_nxt   = 5'h00;
                    state_nxt = duhbp_pkg::HOST_RECOVER;
                    if (!write_r) begin
                        rd_data_nxt = filt_r.data;
                    end
                end
            end
            duhbp_pkg::HOST_RECOVER: begin
                if (cnt_r == RECOVER_LAST) begin
                    done_nxt  = 1'b1;
                    state_nxt = duhbp_pkg::HOST_IDLE;
                end
            end
            default: begin
                state_nxt = duhbp_pkg::HOST_IDLE;
            end
        endcase
        // pin levels decoded from the next state, so every pin leaves a flop
        drv_nxt = 6'h3e;
        if (state_nxt != duhbp_pkg::HOST_IDLE) begin
            drv_nxt[5]   = 1'b0;
            drv_nxt[4:3] = chan_nxt ? 2'b10 : 2'b01;
            drv_nxt[0]   = write_nxt;
        end
        if (state_nxt == duhbp_pkg::HOST_STROBE) begin
            drv_nxt[2:1] = write_nxt ? 2'b10 : 2'b01;
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            state_r   <= duhbp_pkg::HOST_IDLE;
            cnt_r     <= 5'h00;
            write_r   <= 1'b0;
            chan_r    <= 1'b0;
            addr_r    <= 3'h0;
            data_r    <= 8'h00;
            rd_data_r <= 8'h00;
            done_r    <= 1'b0;
            drv_r     <= 6'h3e;
            s1_r      <= '1;
            s2_r      <= '1;
            s3_r      <= '1;
            filt_r    <= '1;
        end else begin
            state_r   <= state_nxt;
            cnt_r     <= cnt_nxt;
            write_r   <= write_nxt;
            chan_r    <= chan_nxt;
            addr_r    <= addr_nxt;
            data_r    <= data_nxt;
            rd_data_r <= rd_data_nxt;
            done_r    <= done_nxt;
            drv_r     <= drv_nxt;
            s1_r      <= pins_now;
            s2_r      <= s1_r;
            s3_r      <= s2_r;
            filt_r    <= filt_nxt;
        end
    end

    // address and one select held from setup through recovery
    assign bus.reg_select_lines = addr_r;
    assign bus.chan_a_select_n  = drv_r[4];
    assign bus.chan_b_select_n  = drv_r[3];
    assign bus.read_strobe_n    = drv_r[2];
    assign bus.write_strobe_n   = drv_r[1];
    assign bus.host_data_o      = data_r;
    assign bus.host_data_oe     = drv_r[0];

    assign cmd_ready_out  = drv_r[5];
    assign done_out       = done_r;
    assign rd_data_out    = rd_data_r;
    assign irq_out        = filt_r.irq;
    assign tx_ready_n_out = filt_r.tx_ready_n;
    assign rx_ready_n_out = filt_r.rx_ready_n;

endmodule : duhbp_host_end
`default_nettype wire

/* File: test/duhbp_sva.sv */
/*
  Checker for the pins between the host end and the device end.
  Assumes it is instantiated beside the interface in tb_top, on clk_in.
*/
`timescale 1ns/1ps
`default_nettype none
module duhbp_sva (
    // clock and reset
    input  wire logic       clk_in,
    input  wire logic       srst_in,
    // interface signals
    input  wire logic [2:0] reg_select_lines,
    input  wire logic       read_strobe_n,
    input  wire logic       write_strobe_n,
    input  wire logic       chan_a_select_n,
    input  wire logic       chan_b_select_n,
    input  wire logic       host_data_oe,
    input  wire logic [7:0] dev_data_o,
    input  wire logic       dev_data_oe,
    input  wire logic       chan_a_irq_oe,
    input  wire logic       chan_b_irq_oe,
    input  wire logic       chan_a_aux_out2_n,
    input  wire logic       chan_b_aux_out2_n
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (srst_in);

    AST_RD_FETCH: assert property (($fell(read_strobe_n) && (chan_a_select_n != chan_b_select_n))
        |-> ##[3:8] dev_data_oe) else $error("read fetch not driven");
    AST_RD_HOLD: assert property ((dev_data_oe && $past(dev_data_oe) && !read_strobe_n)
        |-> $stable(dev_data_o)) else $error("read byte moved");
    AST_RD_RELEASE: assert property ($rose(read_strobe_n) |-> ##[4:9] !dev_data_oe)
        else $error("read drive not released");
    AST_WR_DRIVE: assert property (!write_strobe_n |-> (!dev_data_oe && host_data_oe))
        else $error("bus driver wrong in write");
    AST_NO_CLASH: assert property (!(dev_data_oe && host_data_oe))
        else $error("both ends drive data");
    AST_UNSEL: assert property ((chan_a_select_n && chan_b_select_n) [*8] |-> !dev_data_oe)
        else $error("drive without select");
    AST_IRQ_A: assert property (chan_a_irq_oe == !chan_a_aux_out2_n)
        else $error("channel a irq and aux2 disagree");
    AST_IRQ_B: assert property (chan_b_irq_oe == !chan_b_aux_out2_n)
        else $error("channel b irq and aux2 disagree");
    AST_RST_IRQ: assert property ($fell(srst_in) |-> (!chan_a_irq_oe && !chan_b_irq_oe
        && chan_a_aux_out2_n && chan_b_aux_out2_n)) else $error("irq not released");
    AST_ONE_STROBE: assert property (read_strobe_n || write_strobe_n)
        else $error("both strobes low");
    AST_ONE_SEL: assert property (chan_a_select_n || chan_b_select_n)
        else $error("both selects low");
    AST_ADDR_STABLE: assert property ((!read_strobe_n && $past(!read_strobe_n))
        |-> $stable(reg_select_lines)) else $error("address moved in strobe");
endmodule : duhbp_sva
`default_nettype wire

/* File: test/tb_top.sv */
/*
  Testbench joining the host end and the device end through the pin
  interface; commands go in at the host, status at the device.
  Assumes one 40 MHz clock and the command timing of the host end.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic       clk_in    = 1'b0;
    logic       srst_in   = 1'b1;
    logic [1:0] irq_req   = 2'h0;
    logic [1:0] tx_space  = 2'h0;
    logic [1:0] rx_avail  = 2'h0;
    logic       cmd_valid = 1'b0;
    logic       cmd_write = 1'b0;
    logic       cmd_chan  = 1'b0;
    logic [2:0] cmd_addr  = 3'h0;
    logic [7:0] cmd_data  = 8'h00;
    logic       cmd_ready, done, wr_pulse, rd_pulse, acc_chan;
    logic [2:0] acc_addr;
    logic [7:0] wr_data, rd_data, d;
    logic [1:0] irq_en, irq_f, tx_rdy_n, rx_rdy_n, e;
    int         errors    = 0;
    int         tests_run = 0;
    int         cycles    = 0;
    int         rd_cnt    = 0;
    int         wr_cnt    = 0;

    always #12.5 clk_in = ~clk_in;

    duhbp_bus_if bus ();
    duhbp_device_end u_duhbp_device_end (.clk_in(clk_in), .srst_in(srst_in),
        .bus(bus.device_port), .chan_irq_req_in(irq_req), .chan_tx_space_in(tx_space),
        .chan_rx_avail_in(rx_avail), .wr_pulse_out(wr_pulse), .rd_pulse_out(rd_pulse),
        .acc_chan_out(acc_chan), .acc_addr_out(acc_addr), .wr_data_out(wr_data),
        .irq_enable_out(irq_en));
    duhbp_host_end u_duhbp_host_end (.clk_in(clk_in), .srst_in(srst_in),
        .bus(bus.host_port), .cmd_valid_in(cmd_valid), .cmd_write_in(cmd_write),
        .cmd_chan_in(cmd_chan), .cmd_addr_in(cmd_addr), .cmd_data_in(cmd_data),
        .cmd_ready_out(cmd_ready), .done_out(done), .rd_data_out(rd_data),
        .irq_out(irq_f), .tx_ready_n_out(tx_rdy_n), .rx_ready_n_out(rx_rdy_n));
    duhbp_sva u_duhbp_sva (.clk_in(clk_in), .srst_in(srst_in),
        .reg_select_lines(bus.reg_select_lines), .read_strobe_n(bus.read_strobe_n),
        .write_strobe_n(bus.write_strobe_n), .chan_a_select_n(bus.chan_a_select_n),
        .chan_b_select_n(bus.chan_b_select_n), .host_data_oe(bus.host_data_oe),
        .dev_data_o(bus.dev_data_o), .dev_data_oe(bus.dev_data_oe),
        .chan_a_irq_oe(bus.chan_a_irq_oe), .chan_b_irq_oe(bus.chan_b_irq_oe),
        .chan_a_aux_out2_n(bus.chan_a_aux_out2_n), .chan_b_aux_out2_n(bus.chan_b_aux_out2_n));

    task automatic final_report();
        $display("checks %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : final_report

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("BAD %0t %s got %h want %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask : wait_cyc

    // one command, taken at the edge after valid rises, ends at done
    task automatic do_cmd(input logic wr, input logic ch, input logic [2:0] a,
                          input logic [7:0] dat);
        int n;
        n = 0;
        @(posedge clk_in);
        cmd_valid <= 1'b1;
        cmd_write <= wr;
        cmd_chan  <= ch;
        cmd_addr  <= a;
        cmd_data  <= dat;
        @(posedge clk_in);
        cmd_valid <= 1'b0;
        while (done !== 1'b1 && n < 60) begin
            @(posedge clk_in);
            #1;
            n++;
        end
        chk({6'h00, cmd_ready, done}, 8'h03, "command done");
    endtask : do_cmd

    always @(posedge clk_in) begin
        cycles <= cycles + 1;
        if (rd_pulse === 1'b1) rd_cnt <= rd_cnt + 1;
        if (wr_pulse === 1'b1) wr_cnt <= wr_cnt + 1;
        if (cycles == 6000) begin
            errors++;
            $display("BAD %0t run too long", $time);
            final_report();
        end
    end

    initial begin
        repeat (2) @(posedge clk_in);
        srst_in <= 1'b0;
        wait_cyc(8);
        chk({6'h00, irq_en}, 8'h00, "control bit3 reset");
        chk({6'h00, irq_f}, 8'h03, "irq released at reset");
        for (int c = 0; c < 2; c++) begin
            for (int a = 0; a < 8; a++) begin
                do_cmd(1'b0, c[0], a[2:0], 8'h00);
                chk(rd_data, duhbp_pkg::REG_RESET_VAL, "reset value");
            end
        end
        for (int c = 0; c < 2; c++) begin
            for (int a = 0; a < 8; a++) begin
                d = {1'b1, c[0], 3'h2, a[2:0]};
                do_cmd(1'b1, c[0], a[2:0], d);
                chk({acc_chan, acc_addr, 4'h0}, {c[0], a[2:0], 4'h0}, "write place");
                chk(wr_data, d, "write byte");
            end
        end
        for (int c = 0; c < 2; c++) begin
            for (int a = 0; a < 8; a++) begin
                do_cmd(1'b0, c[0], a[2:0], 8'h00);
                chk(rd_data, {1'b1, c[0], 3'h2, a[2:0]}, "read back");
            end
        end
        // enable one channel's irq at a time, then release it again
        for (int c = 0; c < 2; c++) begin
            e = c[0] ? 2'h1 : 2'h2;
            @(posedge clk_in);
            irq_req <= 2'h0;
            do_cmd(1'b1, c[0], duhbp_pkg::MODEM_CTRL_IDX,
                   8'h01 << duhbp_pkg::MODEM_CTRL_OUT2);
            wait_cyc(10);
            chk({6'h00, irq_en}, {6'h00, ~e}, "irq enable");
            chk({6'h00, irq_f}, {6'h00, e}, "irq driven low");
            chk({6'h00, bus.chan_b_aux_out2_n, bus.chan_a_aux_out2_n}, {6'h00, e},
                "aux2 low");
            do_cmd(1'b1, c[0], duhbp_pkg::MODEM_CTRL_IDX, 8'h00);
            wait_cyc(10);
            chk({6'h00, irq_f}, 8'h03, "irq released");
            chk({6'h00, bus.chan_b_aux_out2_n, bus.chan_a_aux_out2_n}, 8'h03,
                "aux2 high");
        end
        for (int p = 0; p < 4; p++) begin
            @(posedge clk_in);
            tx_space <= p[1:0];
            rx_avail <= ~p[1:0];
            wait_cyc(10);
            chk({6'h00, tx_rdy_n}, {6'h00, ~p[1:0]}, "tx ready");
            chk({6'h00, rx_rdy_n}, {6'h00, p[1:0]}, "rx ready");
            chk({6'h00, bus.chan_b_tx_ready_n, bus.chan_a_tx_ready_n}, {6'h00, ~p[1:0]},
                "tx ready pins");
        end
        chk(rd_cnt[7:0], 8'h20, "read pulses");
        chk(wr_cnt[7:0], 8'h14, "write pulses");
        final_report();
    end
endmodule : tb_top
`default_nettype wire
